// ===== logic/fls_consts.vh
// Constants for the flat-panel link serializer: timing, slot layout and
// the fixed forwarded-clock pattern. Included by the serializer module only.
`ifndef FLS_CONSTS_VH
`define FLS_CONSTS_VH

// System clock period in ns (100 MHz).
`define FLS_CLK_NS          10
// Lock time after a stable pixel clock, in ms.
`define FLS_LOCK_MS         10
// Longest delay from power-down request to disabled outputs, in ns.
`define FLS_PDD_NS          100
// Parallel word width, channel count and bit slots per period.
`define FLS_WORD_W          28
`define FLS_CHANNELS        4
`define FLS_SLOTS           7
`define FLS_LAST_SLOT       3'h6
`define FLS_FIRST_SLOT      3'h0
// Forwarded-clock level in slots 0..6, slot 0 in bit 0.
`define FLS_FWD_PATTERN     7'h63
// Cycles without a rising pixel clock edge before the clock counts as stopped.
`define FLS_STALL_CYCLES    255
// Input bundle layout after the synchroniser.
`define FLS_SYNC_W          31
`define FLS_SYNC_CLK        28
`define FLS_SYNC_EDGE       29
`define FLS_SYNC_PWR        30

`endif

// ===== logic/fls_sync2.v
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a level that may change at any time.
`timescale 1ns/100ps
module fls_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rstn,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        meta     <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta     <= async_in;
        sync_out <= meta;
    end
end

endmodule // fls_sync2

// ===== logic/fls_serializer.v
// Flat-panel link serializer: samples 28 pixel inputs once per pixel clock
// and sends them as seven slots per period on four data pairs plus a
// forwarded clock pair. Assumes all pins are asynchronous to clk_sys and
// that the pixel clock is several clk_sys cycles long.
//
// How it works
// - each pixel clock period, all 28 inputs are sent on four channels.
// - a forwarded clock, locked to the pixel clock, goes out on a fifth pair.
// - edge select high samples on the rising edge, low on the falling edge.
// - framing starts at the rising edge, which falling-edge receivers accept.
// - power-down low tri-states all pairs and stops internal activity.
// - each channel sends seven slots per period, slot 0 at period start.
// - outputs are held idle until the clock has been stable for 10 ms.
// - outputs reach high impedance within 100 ns of power-down.
`timescale 1ns/100ps
`include "fls_consts.vh"
module fls_serializer #(
    parameter LOCK_CYCLES = `FLS_LOCK_MS * 1000000 / `FLS_CLK_NS,
    parameter CNT_W       = 8
) (
    // Clock and reset
    input  wire                     clk_sys,
    input  wire                     rstn,
    // Pixel side pins
    input  wire                     input_pixel_clock,
    input  wire [`FLS_WORD_W-1:0]   pixel_in,
    input  wire                     strobe_edge_select,
    input  wire                     power_down_n,
    // Serial data pairs
    output reg  [`FLS_CHANNELS-1:0] serial_data_pair_p,
    output reg  [`FLS_CHANNELS-1:0] serial_data_pair_n,
    output reg                      serial_data_oe,
    // Forwarded clock pair
    output reg                      forwarded_clock_pair_p,
    output reg                      forwarded_clock_pair_n,
    output reg                      forwarded_clock_oe,
    // Status
    output reg                      link_locked
);

localparam [CNT_W-1:0] SLOT_STEP = `FLS_SLOTS;
localparam [CNT_W-1:0] STALL_MAX = `FLS_STALL_CYCLES;

wire [`FLS_SYNC_W-1:0] sync_bus;
wire [`FLS_WORD_W-1:0] pix_s;
wire                   clk_s;
wire                   rise_sel;
wire                   pwr_on;

fls_sync2 #(
    .WIDTH    (`FLS_SYNC_W)
) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({power_down_n, strobe_edge_select, input_pixel_clock,
                pixel_in}),
    .sync_out (sync_bus)
);

assign pix_s    = sync_bus[`FLS_WORD_W-1:0];
assign clk_s    = sync_bus[`FLS_SYNC_CLK];
assign rise_sel = sync_bus[`FLS_SYNC_EDGE];
assign pwr_on   = sync_bus[`FLS_SYNC_PWR];

// Edge detection on the synchronised pixel clock.
reg  clk_d;
wire clk_rise = clk_s & ~clk_d;
wire clk_fall = ~clk_s & clk_d;
wire strobe   = rise_sel ? clk_rise : clk_fall;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        clk_d <= 1'b0;
    end else begin
        clk_d <= clk_s;
    end
end

// Capture on the selected strobe edge.
// In rising mode the word also goes straight into the shift register, so
// this copy only matters for the falling edge, half a period earlier.
reg [`FLS_WORD_W-1:0] captured;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        captured <= {`FLS_WORD_W{1'b0}};
    end else if (!pwr_on) begin
        captured <= {`FLS_WORD_W{1'b0}};
    end else if (strobe) begin
        captured <= pix_s;
    end
end

// Period measurement between rising edges, and stall detection.
// A clock held still too long leaves no period to divide into slots, so
// lock is dropped and timing starts again at the next rising edge.
reg  [CNT_W-1:0] per_cnt;
reg  [CNT_W-1:0] period;
reg              stalled;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        per_cnt <= {CNT_W{1'b0}};
        period  <= {CNT_W{1'b0}};
        stalled <= 1'b1;
    end else if (!pwr_on) begin
        per_cnt <= {CNT_W{1'b0}};
        period  <= {CNT_W{1'b0}};
        stalled <= 1'b1;
    end else if (clk_rise) begin
        period  <= per_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        per_cnt <= {CNT_W{1'b0}};
        stalled <= 1'b0;
    end else if (per_cnt == STALL_MAX) begin
        stalled <= 1'b1;
    end else begin
        per_cnt <= per_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

// Lock timer: the clock must run without a stall for the lock time.
// The counter stops at the limit, so it can never wrap and drop lock.
reg [31:0] lock_cnt;

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        lock_cnt    <= 32'h0;
        link_locked <= 1'b0;
    end else if (!pwr_on || stalled) begin
        lock_cnt    <= 32'h0;
        link_locked <= 1'b0;
    end else if (lock_cnt >= LOCK_CYCLES - 1) begin
        link_locked <= 1'b1;
    end else begin
        lock_cnt <= lock_cnt + 32'h1;
    end
end

// Slot timing: a period of P cycles is split into seven slots by an
// accumulator stepping 7 per cycle, so slots track any period from 7 to 249 cycles.
reg [`FLS_WORD_W-1:0] shift_word;
reg [2:0]             slot;
reg [CNT_W-1:0]       acc;
reg [CNT_W-1:0]       next_acc;
reg [2:0]             next_slot;

always @* begin
    next_acc  = acc + SLOT_STEP;
    next_slot = slot;
    if (next_acc >= period && slot != `FLS_LAST_SLOT) begin
        next_acc  = next_acc - period;
        next_slot = slot + 3'h1;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        shift_word <= {`FLS_WORD_W{1'b0}};
        slot       <= `FLS_FIRST_SLOT;
        acc        <= {CNT_W{1'b0}};
    end else if (!pwr_on || stalled) begin
        shift_word <= {`FLS_WORD_W{1'b0}};
        slot       <= `FLS_FIRST_SLOT;
        acc        <= {CNT_W{1'b0}};
    end else if (clk_rise) begin
        // Framing always restarts on the rising edge.
        shift_word <= strobe ? pix_s : captured;
        slot       <= `FLS_FIRST_SLOT;
        acc        <= {CNT_W{1'b0}};
    end else begin
        slot <= next_slot;
        acc  <= next_acc;
    end
end

// Output bits, one channel per loop pass.
wire [`FLS_CHANNELS-1:0] data_bit;
wire [`FLS_SLOTS-1:0]    fwd_pattern = `FLS_FWD_PATTERN;
wire                     drive_on    = pwr_on;
wire                     send_on     = pwr_on & link_locked;

genvar ch;
generate
    for (ch = 0; ch < `FLS_CHANNELS; ch = ch + 1) begin : g_ch
        wire [`FLS_SLOTS-1:0] lane =
            shift_word[ch*`FLS_SLOTS +: `FLS_SLOTS];
        assign data_bit[ch] = lane[slot];
    end
endgenerate

// Power-down reaches the enables three cycles after the pin.
// Until lock the pairs stay enabled but idle, so a receiver sees a steady
// level rather than words framed by a period not yet measured.
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        serial_data_pair_p     <= {`FLS_CHANNELS{1'b0}};
        serial_data_pair_n     <= {`FLS_CHANNELS{1'b1}};
        serial_data_oe         <= 1'b0;
        forwarded_clock_pair_p <= 1'b0;
        forwarded_clock_pair_n <= 1'b1;
        forwarded_clock_oe     <= 1'b0;
    end else begin
        serial_data_oe     <= drive_on;
        forwarded_clock_oe <= drive_on;
        if (send_on) begin
            serial_data_pair_p     <= data_bit;
            serial_data_pair_n     <= ~data_bit;
            forwarded_clock_pair_p <= fwd_pattern[slot];
            forwarded_clock_pair_n <= ~fwd_pattern[slot];
        end else begin
            serial_data_pair_p     <= {`FLS_CHANNELS{1'b0}};
            serial_data_pair_n     <= {`FLS_CHANNELS{1'b1}};
            forwarded_clock_pair_p <= 1'b0;
            forwarded_clock_pair_n <= 1'b1;
        end
    end
end

endmodule // fls_serializer

// ===== verif/fls_serializer_assertions.sv
// Concurrent checks on the serializer's pins.
// Bound into every fls_serializer instance; sees its ports only.
`timescale 1ns/100ps
module fls_serializer_checker (
    // Clock and reset
    input wire       clk_sys,
    input wire       rstn,
    // Pins
    input wire       power_down_n,
    input wire [3:0] serial_data_pair_p,
    input wire [3:0] serial_data_pair_n,
    input wire       serial_data_oe,
    input wire       forwarded_clock_pair_p,
    input wire       forwarded_clock_pair_n,
    input wire       forwarded_clock_oe,
    input wire       link_locked
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_DATA_DIFF:
        assert property (serial_data_pair_n == ~serial_data_pair_p)
        else $error("data pair halves equal");
    AST_CLK_DIFF:
        assert property (forwarded_clock_pair_n == ~forwarded_clock_pair_p)
        else $error("clock pair halves equal");
    AST_OE_MATCH:
        assert property (serial_data_oe == forwarded_clock_oe)
        else $error("enables disagree");
    AST_PD_OFF:
        assert property (!power_down_n [*4] |->
            !serial_data_oe && !link_locked)
        else $error("pairs on in power down");
    AST_PD_DELAY:
        assert property ($fell(power_down_n) |-> ##[1:10] !forwarded_clock_oe)
        else $error("power down too slow");
    AST_IDLE:
        assert property (!link_locked && !$past(link_locked) |->
            serial_data_pair_p == 4'h0 && !forwarded_clock_pair_p)
        else $error("traffic before lock");
    AST_LOW_RUN:
        assert property ($fell(forwarded_clock_pair_p) && link_locked |->
            !forwarded_clock_pair_p [*5])
        else $error("clock low run short");
    AST_PERIOD:
        assert property ($rose(forwarded_clock_pair_p) |=>
            !$rose(forwarded_clock_pair_p) [*8])
        else $error("clock rises too often");
endmodule // fls_serializer_checker

bind fls_serializer fls_serializer_checker u_chk (.clk_sys, .rstn,
    .power_down_n, .serial_data_pair_p, .serial_data_pair_n,
    .serial_data_oe, .forwarded_clock_pair_p, .forwarded_clock_pair_n,
    .forwarded_clock_oe, .link_locked);

// ===== verif/fls_pixel_source.sv
// Graphics controller model: pixel clock and pixel word.
// The word is steady only around the chosen sampling edge.
`timescale 1ns/100ps
module fls_pixel_source (
    // Control
    input  wire        run,
    input  wire        rise_strobe,
    input  wire [27:0] word,
    // Pixel pins
    output reg         pclk,
    output reg  [27:0] pix
);
    initial begin
        pclk = 1'b0;
        pix  = 28'h0;
    end
    // The clock finishes its high phase and then stands low.
    always #80 if (run || pclk) pclk = ~pclk;
    // An inverted word near the other edge exposes a wrong sampling edge.
    always @(pclk) #20 pix = (pclk == rise_strobe) ? ~word : word;
endmodule // fls_pixel_source

// ===== verif/fls_serializer_test.sv
// Self-checking bench for fls_serializer driven by a pixel source model.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module fls_serializer_test;
    reg         clk_sys = 1'b0;
    reg         rstn = 1'b0;
    reg         run = 1'b0;
    reg         rise = 1'b0;
    reg         power_down_n = 1'b1;
    reg  [27:0] word = 28'h0;
    wire        pclk;
    wire [27:0] pix;
    wire [3:0]  dp;
    wire        fwd, doe, coe, lock;
    int         error_cnt = 0;
    int         num_checks = 0;
    int         cyc = 0;

    fls_pixel_source src (.run(run), .rise_strobe(rise), .word(word),
        .pclk(pclk), .pix(pix));
    fls_serializer #(.LOCK_CYCLES(50)) uut (.clk_sys(clk_sys),
        .rstn(rstn), .input_pixel_clock(pclk), .pixel_in(pix),
        .strobe_edge_select(rise), .power_down_n(power_down_n),
        .serial_data_pair_p(dp), .serial_data_pair_n(),
        .serial_data_oe(doe), .forwarded_clock_pair_p(fwd),
        .forwarded_clock_pair_n(), .forwarded_clock_oe(coe),
        .link_locked(lock));

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [27:0] got, exp, input string s);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, s);
        end
    endtask
    task automatic wait_lock;
        int i;
        for (i = 0; i < 400 && lock !== 1'b1; i++) tick(1);
    endtask
    task automatic t_lock;
        run = 1'b1;
        tick(40);
        chk({lock, dp}, 5'h0, "early lock");
        wait_lock;
        chk(lock, 1'b1, "no lock");
        $display("lock test done");
    endtask
    // Slots are read mid-slot, timed from the fall of the forwarded clock.
    task automatic t_word(input logic r, input logic [27:0] w);
        logic [20:0] off = {3'h2, 3'h3, 3'h2, 3'h2, 3'h3, 3'h2, 3'h1};
        logic [27:0] got;
        logic [6:0] gf;
        logic p;
        int n, s, c;
        rise = r;
        word = w;
        tick(48);
        for (n = 0; n < 40; n++) begin
            p = fwd;
            tick(1);
            if (p && !fwd) break;
        end
        for (n = 0; n < 7; n++) begin
            tick(off[3*n +: 3]);
            s = (n + 2) % 7;
            gf[s] = fwd;
            for (c = 0; c < 4; c++) got[7*c+s] = dp[c];
        end
        chk(got, w, "slot data");
        chk(gf, 7'h63, "clock pattern");
        $display("word test done");
    endtask
    task automatic t_pd;
        power_down_n = 1'b0;
        tick(10);
        chk({doe, coe, lock}, 3'h0, "pairs on");
        power_down_n = 1'b1;
        wait_lock;
        chk({doe, coe, lock}, 3'h7, "no restart");
        $display("power down test done");
    endtask
    // A stopped pixel clock must drop lock and idle the pairs.
    task automatic t_stall;
        run = 1'b0;
        tick(300);
        chk({lock, dp, fwd}, 6'h0, "lock kept on stop");
        run = 1'b1;
        wait_lock;
        chk(lock, 1'b1, "no relock");
        $display("stall test done");
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        tick(4);
        rstn = 1'b1;
        tick(2);
        chk({lock, dp}, 5'h0, "idle after reset");
        t_lock;
        t_word(1'b1, 28'h9c3a5e6);
        t_word(1'b0, 28'h5a1e3c7);
        t_pd;
        t_stall;
        t_word(1'b1, 28'h36c95a3);
        end_of_test;
    end
endmodule // fls_serializer_test
